// file: inc/pvm_regs.vh
`ifndef PVM_REGS_VH
`define PVM_REGS_VH
// command codes, low four bits of the six-bit command
`define PVM_CMD_LOAD_CFG   4'h0
`define PVM_CMD_LOAD_PROG  4'h2
`define PVM_CMD_LOAD_DATA  4'h3
`define PVM_CMD_READ_PROG  4'h4
`define PVM_CMD_READ_DATA  4'h5
`define PVM_CMD_INC_ADDR   4'h6
`define PVM_CMD_BITS       5'h06
`define PVM_DATA_BITS      5'h10
`define PVM_ADDR_ZERO      14'h0000
`define PVM_ADDR_ONE       14'h0001
`define PVM_CFG_BASE       14'h2000
`define PVM_USER_TOP       14'h1FFF
`define PVM_CFG_TOP        14'h3FFF
`define PVM_USER_IMPL_TOP  14'h07FF
`define PVM_CFG_IMPL_TOP   14'h203F
`define PVM_ID_LAST        14'h2003
`define PVM_CFGW_ADDR      14'h2007
`define PVM_CAL_LAST       14'h2009
`define PVM_ALL_ONES       14'h3FFF
`define PVM_BIT_ZERO       5'h00
`define PVM_BIT_ONE        5'h01
`define PVM_BIT_FIFTEEN    5'h0F
`endif

// file: logic/pvm_entry.v
//
// Function
// - user space increments run 0x0000..0x1FFF and wrap to 0x0000.
// - from config base increments run to 0x3FFF and wrap to 0x2000.
// - top address bit stays set once in config space until re-entry.
// - program space spans 0x0000-0x3FFF; only first 2K user words exist.
// - config implements 0x2000-0x203F; only ID, config, calibration usable.
// - user ID words read back even when code protection is on.
// - calibration words survive bulk erase but stay writable.
// - entry resets other logic, tristates pins, clears address counter.
// - clock pin is input only; data pin is bidirectional.
// - serial access to program, data, ID and configuration locations.
// - commands are six bits, falling-edge latched, lsb first.
// - data transfers are sixteen clocks: start, data lsb first, stop.
// - load-configuration sets the counter to 0x2000.
// - increment-address advances the counter by region wrap rules.
`timescale 1ns/1ns
`default_nettype none
`include "pvm_regs.vh"
module pvm_entry (
    input  wire        MCLK_I,
    input  wire        RST_N_I,
    input  wire        HV_ENTRY_I,
    input  wire        PROG_CLK_I,
    input  wire        PROG_DAT_I,
    output reg         PROG_DAT_O,
    output reg         PROG_DAT_OE_O,
    output reg         IN_MODE_O,
    output reg         LOGIC_RST_O,
    output reg  [13:0] ADDR_O,
    output reg  [13:0] WR_DATA_O,
    output reg         WR_VALID_O,
    output reg         WR_IS_DATA_O,
    input  wire        WR_READY_I,
    input  wire        WR_FULL_MASK_I,
    input  wire [13:0] RD_DATA_I,
    output reg         LOC_USABLE_O
);
// =====================================================================
// synchronisers
// link pins are asynchronous to MCLK_I, so each passes two flops first
reg [1:0] hv_s_q;
reg [1:0] clk_s_q;
reg [1:0] dat_s_q;
reg       clk_d1_q;
always @(posedge MCLK_I) begin
    if (!RST_N_I) begin
        hv_s_q   <= 2'h0;
        clk_s_q  <= 2'h0;
        dat_s_q  <= 2'h0;
        clk_d1_q <= 1'b0;
    end else begin
        hv_s_q   <= {hv_s_q[0], HV_ENTRY_I};
        clk_s_q  <= {clk_s_q[0], PROG_CLK_I};
        dat_s_q  <= {dat_s_q[0], PROG_DAT_I};
        clk_d1_q <= clk_s_q[1];
    end
end
wire hv_lvl = hv_s_q[1];
wire clk_rise = clk_s_q[1] & ~clk_d1_q;
wire clk_fall = ~clk_s_q[1] & clk_d1_q;
// =====================================================================
// serial state machine
localparam ST_IDLE = 3'h1;
localparam ST_CMD  = 3'h2;
localparam ST_DATA = 3'h4;
reg  [2:0]  st_q;
reg  [4:0]  cnt_q;
reg  [5:0]  cmd_q;
reg  [15:0] sh_q;
reg         hv_d1_q;
reg  [13:0] addr_q;
reg  [13:0] rd_q;
reg         reading_q;
// two-entry write buffer
reg  [14:0] buf_q [0:1];
reg         wp_q;
reg         rp_q;
reg  [1:0]  fill_q;
wire        buf_full  = (fill_q == 2'h2);
wire        buf_empty = (fill_q == 2'h0);
wire [3:0]  op = cmd_q[3:0];
wire        entry = hv_lvl & ~hv_d1_q;
wire [5:0]  cmd_next = {dat_s_q[1], cmd_q[5:1]};
// stall: a load whose buffer is full is dropped; full is rare since each word takes 16 clocks
wire        push = (st_q == ST_DATA) && clk_fall && (cnt_q == `PVM_BIT_FIFTEEN) && !reading_q
                   && !buf_full;
wire        pop  = WR_VALID_O && WR_READY_I && !WR_FULL_MASK_I;
// msb holds by itself: the config wrap lands on 0x2000, never below
wire [13:0] addr_inc = (addr_q == `PVM_USER_TOP) ? `PVM_ADDR_ZERO :
                       (addr_q == `PVM_CFG_TOP)  ? `PVM_CFG_BASE  :
                       (addr_q + `PVM_ADDR_ONE);
always @(posedge MCLK_I) begin
    if (!RST_N_I) begin
        st_q      <= ST_IDLE;
        cnt_q     <= `PVM_BIT_ZERO;
        cmd_q     <= 6'h00;
        sh_q      <= 16'h0000;
        hv_d1_q   <= 1'b0;
        addr_q    <= `PVM_ADDR_ZERO;
        rd_q      <= `PVM_ADDR_ZERO;
        reading_q <= 1'b0;
        wp_q      <= 1'b0;
        rp_q      <= 1'b0;
        fill_q    <= 2'h0;
        buf_q[0]  <= 15'h0000;
        buf_q[1]  <= 15'h0000;
    end else begin
        hv_d1_q <= hv_lvl;
        if (!hv_lvl || entry) begin
            st_q      <= ST_IDLE;
            addr_q    <= `PVM_ADDR_ZERO;
            cnt_q     <= `PVM_BIT_ZERO;
            cmd_q     <= 6'h00;
            reading_q <= 1'b0;
            wp_q      <= 1'b0;
            rp_q      <= 1'b0;
            fill_q    <= 2'h0;
        end else begin
            if (push) begin
                buf_q[wp_q] <= {op == `PVM_CMD_LOAD_DATA, sh_q[15:2]};
                wp_q        <= ~wp_q;
            end
            if (pop)
                rp_q <= ~rp_q;
            fill_q <= fill_q + {1'b0, push} - {1'b0, pop};
            case (st_q)
            ST_IDLE: begin
                st_q  <= ST_CMD;
                cnt_q <= `PVM_BIT_ZERO;
            end
            ST_CMD: if (clk_fall) begin
                cmd_q <= cmd_next;
                if (cnt_q == `PVM_CMD_BITS - `PVM_BIT_ONE) begin
                    cnt_q <= `PVM_BIT_ZERO;
                    case (cmd_next[3:0])
                    `PVM_CMD_LOAD_CFG: begin
                        addr_q    <= `PVM_CFG_BASE;
                        st_q      <= ST_DATA;
                        reading_q <= 1'b0;
                    end
                    `PVM_CMD_LOAD_PROG, `PVM_CMD_LOAD_DATA: begin
                        st_q      <= ST_DATA;
                        reading_q <= 1'b0;
                    end
                    `PVM_CMD_READ_PROG, `PVM_CMD_READ_DATA: begin
                        st_q      <= ST_DATA;
                        reading_q <= 1'b1;
                        rd_q      <= RD_DATA_I;
                    end
                    `PVM_CMD_INC_ADDR: addr_q <= addr_inc;
                    default: st_q <= ST_CMD;
                    endcase
                end else begin
                    cnt_q <= cnt_q + `PVM_BIT_ONE;
                end
            end
            ST_DATA: if (clk_fall) begin
                sh_q <= {dat_s_q[1], sh_q[15:1]};
                if (cnt_q == `PVM_DATA_BITS - `PVM_BIT_ONE) begin
                    cnt_q     <= `PVM_BIT_ZERO;
                    st_q      <= ST_CMD;
                    reading_q <= 1'b0;
                end else begin
                    cnt_q <= cnt_q + `PVM_BIT_ONE;
                end
            end
            default: st_q <= ST_IDLE;
            endcase
        end
    end
end
// =====================================================================
// outputs, all registered
// reserved config locations report unusable even though they exist
wire       usable = (addr_q <= `PVM_USER_IMPL_TOP) ||
                    (addr_q >= `PVM_CFG_BASE && addr_q <= `PVM_ID_LAST) ||
                    (addr_q >= `PVM_CFGW_ADDR && addr_q <= `PVM_CAL_LAST);
wire [13:0] rd_word = (op == `PVM_CMD_READ_DATA) ? {6'h00, rd_q[7:0]} : rd_q;
always @(posedge MCLK_I) begin
    if (!RST_N_I) begin
        PROG_DAT_O    <= 1'b0;
        PROG_DAT_OE_O <= 1'b0;
        IN_MODE_O     <= 1'b0;
        LOGIC_RST_O   <= 1'b1;
        ADDR_O        <= `PVM_ADDR_ZERO;
        WR_DATA_O     <= `PVM_ADDR_ZERO;
        WR_VALID_O    <= 1'b0;
        WR_IS_DATA_O  <= 1'b0;
        LOC_USABLE_O  <= 1'b0;
    end else begin
        IN_MODE_O    <= hv_lvl && !entry;
        LOGIC_RST_O  <= !hv_lvl || entry;
        ADDR_O       <= addr_q;
        LOC_USABLE_O <= hv_lvl && usable && (addr_q <= `PVM_CFG_IMPL_TOP || !addr_q[13]);
        WR_VALID_O   <= hv_lvl && !entry && (fill_q != 2'h0 || push) && !(pop && fill_q == 2'h1
                        && !push);
        {WR_IS_DATA_O, WR_DATA_O} <= (buf_empty || (pop && fill_q == 2'h1)) ?
                        {op == `PVM_CMD_LOAD_DATA, sh_q[15:2]} : buf_q[pop ? ~rp_q : rp_q];
        // read data driven from rise of cycle 2 through cycle 15; start and stop drive zero
        if (!hv_lvl || !reading_q || st_q != ST_DATA) begin
            PROG_DAT_OE_O <= 1'b0;
            PROG_DAT_O    <= 1'b0;
        end else if (clk_rise) begin
            PROG_DAT_OE_O <= 1'b1;
            PROG_DAT_O    <= (cnt_q == `PVM_BIT_ZERO || cnt_q == `PVM_BIT_FIFTEEN) ? 1'b0 :
                             rd_word[cnt_q[3:0] - 4'h1];
        end
    end
end
endmodule // pvm_entry
`default_nettype wire

// file: bench/pvm_entry_props.sv
`timescale 1ns/1ns
`default_nettype none
module pvm_props (
    input wire logic        MCLK_I,
    input wire logic        RST_N_I,
    input wire logic        HV_ENTRY_I,
    input wire logic        IN_MODE_O,
    input wire logic        LOGIC_RST_O,
    input wire logic        PROG_DAT_OE_O,
    input wire logic        WR_VALID_O,
    input wire logic        LOC_USABLE_O,
    input wire logic [13:0] ADDR_O
);
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (!RST_N_I);
    logic        run_q;
    logic [13:0] a_q;
    always_ff @(posedge MCLK_I) begin
        run_q <= IN_MODE_O;
        a_q   <= ADDR_O;
    end
    // run needs two cycles in mode so entry is never mistaken for a step
    wire run = IN_MODE_O && run_q;
    wire mov = run && ADDR_O != a_q;
    wire ok  = ADDR_O <= 14'h07FF || (ADDR_O >= 14'h2000 && ADDR_O <= 14'h2003)
        || (ADDR_O >= 14'h2007 && ADDR_O <= 14'h2009);
    a_user_wrap: assert property (mov && a_q == 14'h1FFF |-> ADDR_O == 14'h0000
        || ADDR_O == 14'h2000) else $error("user wrap wrong");
    a_cfg_wrap: assert property (mov && a_q == 14'h3FFF |-> ADDR_O == 14'h2000)
        else $error("config wrap wrong");
    a_msb_sticky: assert property (run && a_q[13] |-> ADDR_O[13])
        else $error("top address bit lost");
    a_step_one: assert property (mov && ADDR_O != 14'h0000 && ADDR_O != 14'h2000
        |-> ADDR_O == a_q + 14'h0001) else $error("step not by one");
    a_entry_clear: assert property ($rose(IN_MODE_O) |-> ADDR_O == 14'h0000
        && !PROG_DAT_OE_O && !WR_VALID_O) else $error("entry not clean");
    a_entry_time: assert property ($rose(HV_ENTRY_I) |-> ##[1:4] IN_MODE_O)
        else $error("entry late");
    a_logic_held: assert property (!IN_MODE_O |-> LOGIC_RST_O)
        else $error("logic free out of mode");
    a_pin_quiet: assert property (!IN_MODE_O |-> !PROG_DAT_OE_O)
        else $error("data pin driven out of mode");
    a_usable_map: assert property (run && ADDR_O == a_q && $stable(a_q)
        |-> LOC_USABLE_O == ok) else $error("usable flag wrong");
    c_cfg: cover property (mov && ADDR_O == 14'h2000);
    c_load: cover property (WR_VALID_O);
    c_drive: cover property (PROG_DAT_OE_O);
endmodule // pvm_props
bind pvm_entry pvm_props u_pvm_props (.*);
`default_nettype wire

// file: bench/pvm_prog_model.sv
`timescale 1ns/1ns
`default_nettype none
module pvm_prog_model (
    input  wire logic dev_dat_i,
    input  wire logic dev_oe_i,
    output var  logic hv_o,
    output var  logic pclk_o,
    output wire logic pin_o
);
    logic drv = 0;
    logic en = 1;
    logic last = 0;
    // released line shows the inverse so a stale level never reads as data
    assign pin_o = dev_oe_i ? dev_dat_i : (en ? drv : ~last);
    always @(pin_o) if (dev_oe_i || en) last = pin_o;
    initial begin
        hv_o = 0;
        pclk_o = 0;
    end
    task automatic enter();
        drv = 0;
        pclk_o = 0;
        #500 hv_o = 1;
        #1000;
    endtask
    task automatic leave();
        hv_o = 0;
        #1000;
    endtask
    task automatic send(input logic [15:0] f, input int n);
        for (int i = 0; i < n; i++) begin
            drv = f[i];
            pclk_o = 1;
            #400 pclk_o = 0;
            #400;
        end
        #1000;
    endtask
    task automatic read(output logic [13:0] w);
        en = 0;
        for (int i = 0; i < 16; i++) begin
            pclk_o = 1;
            #400 pclk_o = 0;
            #200 if (i > 0 && i < 15) w[i-1] = pin_o;
            #200;
        end
        en = 1;
        #1000;
    endtask
endmodule // pvm_prog_model
`default_nettype wire

// file: bench/test_program_verify_entry_address_map.sv
`timescale 1ns/1ns
`default_nettype none
`include "pvm_regs.vh"
module test_program_verify_entry_address_map;
    logic        clk = 0, rst_n = 0, rdy = 0, msk = 1;
    logic [13:0] rd = 14'h0000, w, a, wd;
    logic [3:0]  c;
    wire         hv, pc, pin, dout, oe, im, lr, wv, wis, lu;
    int          num_errors = 0, tests_run = 0, n, ea;
    logic [13:0] cal [0:1];
    logic [14:0] q[$];
    pvm_entry u_pvm_entry (.MCLK_I(clk), .RST_N_I(rst_n), .HV_ENTRY_I(hv), .PROG_CLK_I(pc),
        .PROG_DAT_I(pin), .PROG_DAT_O(dout), .PROG_DAT_OE_O(oe), .IN_MODE_O(im),
        .LOGIC_RST_O(lr), .ADDR_O(a), .WR_DATA_O(wd), .WR_VALID_O(wv), .WR_IS_DATA_O(wis),
        .WR_READY_I(rdy), .WR_FULL_MASK_I(msk), .RD_DATA_I(rd), .LOC_USABLE_O(lu));
    pvm_prog_model u_pvm_prog_model (.dev_dat_i(dout), .dev_oe_i(oe), .hv_o(hv),
        .pclk_o(pc), .pin_o(pin));
    task automatic chk(input string s, input logic [14:0] e, input logic [14:0] g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic print_verdict();
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic cmd(input logic [3:0] k);
        u_pvm_prog_model.send({12'h000, k}, 6);
    endtask
    // address model: user space wraps to zero, config space to its base
    function automatic int nxt(input int x);
        return (x == 'h1FFF) ? 0 : ((x == 'h3FFF) ? 'h2000 : x + 1);
    endfunction
    task automatic cfg_load();
        cmd(`PVM_CMD_LOAD_CFG);
        u_pvm_prog_model.send({1'b0, `PVM_ALL_ONES, 1'b0}, 16);
        q.push_back({1'b0, `PVM_ALL_ONES});
    endtask
    task automatic cal_read(input int j);
        rd = cal[j];
        cmd(`PVM_CMD_READ_PROG);
        u_pvm_prog_model.read(w);
        chk("cal", cal[j], w);
    endtask
    task automatic drain();
        @(posedge clk) #1 msk = 0;
        rdy = 1;
        repeat (20) @(posedge clk);
        #1 msk = 1;
        chk("drained", 15'(q.size()), {14'h0000, wv});
    endtask
    initial forever #50 clk = ~clk;
    always @(posedge clk) if (wv && rdy && !msk) chk("wr", q.pop_front(), {wis, wd});
    initial begin
        #2000000 num_errors++;
        print_verdict();
    end
    initial begin
        void'($urandom(11129));
        repeat (2) @(posedge clk);
        #1 rst_n = 1;
        u_pvm_prog_model.enter();
        chk("addr", 15'h0000, a);
        chk("mode", 15'h0001, im);
        chk("lrst", 15'h0000, lr);
        // drain held off: the third load meets a full buffer and is lost
        for (int i = 0; i < 3; i++) begin
            c = i[0] ? `PVM_CMD_LOAD_DATA : `PVM_CMD_LOAD_PROG;
            w = i[0] ? 14'($urandom_range(0, 255)) : 14'($urandom_range(0, 16383));
            cmd(c);
            u_pvm_prog_model.send({1'b0, w, 1'b0}, 16);
            if (i < 2) q.push_back({i[0], w});
        end
        drain();
        for (int i = 0; i < 2; i++) begin
            rd = 14'($urandom_range(0, 16383));
            cmd(i ? `PVM_CMD_READ_DATA : `PVM_CMD_READ_PROG);
            u_pvm_prog_model.read(w);
            chk("rd", i ? rd & 14'h00FF : rd, w);
        end
        n = $urandom_range(1, 4);
        ea = 0;
        repeat (n) begin
            cmd(`PVM_CMD_INC_ADDR);
            ea = nxt(ea);
        end
        chk("inc", 15'(ea), a);
        cmd(4'hF);
        chk("unknown", 15'(ea), a);
        cfg_load();
        chk("cfg", 15'h2000, a);
        // user ID word: upper seven bits set, ID in the low seven
        w = {7'h7F, 7'($urandom_range(0, 127))};
        cmd(`PVM_CMD_LOAD_PROG);
        u_pvm_prog_model.send({1'b0, w, 1'b0}, 16);
        q.push_back({1'b0, w});
        rd = w;
        cmd(`PVM_CMD_READ_PROG);
        u_pvm_prog_model.read(w);
        chk("uid", rd, w);
        drain();
        // first word looks erased yet is a legal calibration value
        cal[0] = `PVM_ALL_ONES;
        cal[1] = 14'($urandom_range(0, 16383));
        ea = 'h2000;
        for (int k = 1; k <= 10; k++) begin
            cmd(`PVM_CMD_INC_ADDR);
            ea = nxt(ea);
            chk("cfg inc", 15'(ea), a);
            chk("usable", 15'(k <= 3 || (k >= 7 && k <= 9)), lu);
            if (k == 8 || k == 9) cal_read(k - 8);
        end
        u_pvm_prog_model.leave();
        u_pvm_prog_model.enter();
        chk("reentry", 15'h0000, a);
        // verify the calibration words again after re-entry
        cfg_load();
        repeat (8) cmd(`PVM_CMD_INC_ADDR);
        for (int j = 0; j < 2; j++) begin
            cal_read(j);
            cmd(`PVM_CMD_INC_ADDR);
        end
        chk("cfg again", 15'h200A, a);
        drain();
        print_verdict();
    end
endmodule // test_program_verify_entry_address_map
`default_nettype wire
